// File: logic/tcu_pkg.sv
`default_nettype none
package tcu_pkg;

   // Data-space offsets; sync control and flag sit below 0x60, the others in extended space
   localparam logic [7:0] OFF_SYNC_CTRL = 8'h43;
   localparam logic [7:0] OFF_FLAG = 8'h37;
   localparam logic [7:0] OFF_POWER = 8'h64;
   localparam logic [7:0] OFF_MASK = 8'h70;
   localparam logic [7:0] OFF_CTRL_A = 8'hB0;
   localparam logic [7:0] OFF_CTRL_B = 8'hB1;
   localparam logic [7:0] OFF_COUNT = 8'hB2;
   localparam logic [7:0] OFF_CMP_A = 8'hB3;
   localparam logic [7:0] OFF_CMP_B = 8'hB4;
   localparam logic [7:0] OFF_ASYNC_STAT = 8'hB6;

   // Direct I/O window: I/O address plus this offset gives the data-space address
   localparam logic [7:0] IO_SPACE_OFFSET = 8'h20;
   localparam logic [7:0] IO_SPACE_LIMIT = 8'h40;
   localparam logic [7:0] EXT_SPACE_BASE = 8'h60;

   // Field positions
   localparam int BIT_SYNC_HOLD = 7;
   localparam int BIT_ASYNC_PSR = 1;
   localparam int BIT_SHARED_PSR = 0;
   localparam int BIT_POWER = 6;
   localparam int BIT_ASYNC_SEL = 5;
   localparam int BIT_WAVE_HIGH = 3;
   localparam int BIT_FLAG_CMP_B = 2;
   localparam int BIT_FLAG_CMP_A = 1;
   localparam int BIT_FLAG_OVF = 0;

   // Reset values and counter limits
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [7:0] COUNT_BOTTOM = 8'h00;
   localparam logic [7:0] COUNT_MAX = 8'hFF;
   localparam logic [7:0] COUNT_ONE = 8'h01;
   localparam logic [2:0] CLK_SEL_STOP = 3'h0;

   // Waveform mode codes
   localparam logic [2:0] WAVE_NORMAL = 3'h0;
   localparam logic [2:0] WAVE_PHASE_MAX = 3'h1;
   localparam logic [2:0] WAVE_CTC = 3'h2;
   localparam logic [2:0] WAVE_FAST_MAX = 3'h3;
   localparam logic [2:0] WAVE_PHASE_CMP = 3'h5;
   localparam logic [2:0] WAVE_FAST_CMP = 3'h7;

   // Prescaler tap masks, one per clock select code
   localparam logic [9:0] TAP_DIV1 = 10'h000;
   localparam logic [9:0] TAP_DIV8 = 10'h007;
   localparam logic [9:0] TAP_DIV32 = 10'h01F;
   localparam logic [9:0] TAP_DIV64 = 10'h03F;
   localparam logic [9:0] TAP_DIV128 = 10'h07F;
   localparam logic [9:0] TAP_DIV256 = 10'h0FF;
   localparam logic [9:0] TAP_DIV1024 = 10'h3FF;

   // CPU I/O bus request
   typedef struct packed {
      logic ioSpace;
      logic [7:0] addr;
      logic wrEn;
      logic rdEn;
      logic [7:0] wrData;
   } tcu_io_req_t;

   // Whole state of the timer unit
   typedef struct packed {
      logic syncHold;
      logic asyncPsr;
      logic sharedPsr;
      logic powerOn;
      logic asyncSel;
      logic [1:0] waveLow;
      logic waveHigh;
      logic [2:0] clkSel;
      logic [7:0] count;
      logic dirDown;
      logic blockMatch;
      logic [7:0] cmpABuf;
      logic [7:0] cmpBBuf;
      logic [7:0] cmpAAct;
      logic [7:0] cmpBAct;
      logic [2:0] flags;
      logic [2:0] mask;
      logic [9:0] presc;
      logic osc1;
      logic osc2;
      logic osc3;
      logic oscLevel;
      logic [7:0] rdData;
   } tcu_state_t;

   localparam tcu_state_t STATE_RESET = '0;

endpackage : tcu_pkg
`default_nettype wire

// File: logic/tcu_timer_unit.sv
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - With hold set, both prescaler reset bits keep their written value.
// - Writing hold from one to zero clears both prescaler reset bits at once.
// - Shared prescaler reset bit pulses the shared reset, self-clears unless holding.
// - Sync control register decodes at 0x43 data, 0x23 I/O, resets 0x00.
// - I/O address is data offset minus 0x20; extended space is load/store only.
// - Timer runs only while its power bit is one.
// - Bottom status at count 0x00, max status at 0xFF.
// - Top is 0xFF or compare A, chosen by waveform mode.
// - Each request shows as a flag bit, gated by its own mask bit.
// - Timer clock is the I/O clock unless async select picks crystal pin.
// - Clock select zero gives no tick; counter stays put.
// - On each tick the counter clears, increments or decrements per mode.
// - CPU can read and write the counter with or without ticks.
// - A CPU counter write beats any clear or count that same cycle.
// - Three-bit waveform mode: two bits in control A, one in control B.
// - Overflow flag sets per waveform mode and can request an interrupt.
// - Both compare values are matched against the counter continuously.
// - Compare registers are buffered; active value may lag the written value.
// - Match flag sets on the next tick; clears by acknowledge or writing one.
// - A counter write blocks compare matches on the next tick, even stopped.
// - Mode 0 counts up, wraps to 0x00, overflow flags as zero appears.
// - Mode 2 clears the counter on a compare A match.
module tcu_timer_unit (
   // Clock, reset and freeze
   input wire logic clk,
   input wire logic rst_b,
   input wire logic clkEn,
   // CPU I/O bus
   input wire tcu_pkg::tcu_io_req_t ioReq,
   output logic [7:0] ioRdData,
   // Interrupt requests and their service acknowledges
   input wire logic [2:0] intAck,
   output logic [2:0] intReq,
   // Watch crystal oscillator
   input wire logic crystalPin1,
   // Prescaler reset towards the other timers
   output logic sharedPrescalerReset,
   // Counter status
   output logic atBottom,
   output logic atMax
);
   import tcu_pkg::*;

   tcu_state_t s_r;
   tcu_state_t s_nxt;

   logic [7:0] effAddr;
   logic addrOk;
   logic selSync;
   logic selFlag;
   logic selPower;
   logic selMask;
   logic selCtrlA;
   logic selCtrlB;
   logic selCount;
   logic selCmpA;
   logic selCmpB;
   logic selAsync;
   logic [7:0] readMux;

   logic [2:0] waveMode;
   logic isFast;
   logic isPhase;
   logic topIsCmp;
   logic [7:0] topValue;
   logic [9:0] tapMask;
   logic srcTick;
   logic oscRise;
   logic timerTick;
   logic wrCount;
   logic [1:0] cmpHit;

   // Map I/O instruction addresses into data space; I/O space only spans 64 bytes
   always_comb begin
      if (ioReq.ioSpace) begin
         effAddr = ioReq.addr + IO_SPACE_OFFSET;
         addrOk = (ioReq.addr < IO_SPACE_LIMIT);
      end else begin
         effAddr = ioReq.addr;
         addrOk = 1'b1;
      end
   end

   // Register select; extended registers are unreachable by I/O space since effAddr stays below 0x60
   always_comb begin
      selSync = 1'b0;
      selFlag = 1'b0;
      selPower = 1'b0;
      selMask = 1'b0;
      selCtrlA = 1'b0;
      selCtrlB = 1'b0;
      selCount = 1'b0;
      selCmpA = 1'b0;
      selCmpB = 1'b0;
      selAsync = 1'b0;
      if (!addrOk) begin
         selSync = 1'b0;
      end else if (effAddr == OFF_SYNC_CTRL) begin
         selSync = 1'b1;
      end else if (effAddr == OFF_FLAG) begin
         selFlag = 1'b1;
      end else if (effAddr < EXT_SPACE_BASE) begin
         selSync = 1'b0;
      end else if (ioReq.ioSpace) begin
         selSync = 1'b0;
      end else if (effAddr == OFF_POWER) begin
         selPower = 1'b1;
      end else if (effAddr == OFF_MASK) begin
         selMask = 1'b1;
      end else if (effAddr == OFF_CTRL_A) begin
         selCtrlA = 1'b1;
      end else if (effAddr == OFF_CTRL_B) begin
         selCtrlB = 1'b1;
      end else if (effAddr == OFF_COUNT) begin
         selCount = 1'b1;
      end else if (effAddr == OFF_CMP_A) begin
         selCmpA = 1'b1;
      end else if (effAddr == OFF_CMP_B) begin
         selCmpB = 1'b1;
      end else if (effAddr == OFF_ASYNC_STAT) begin
         selAsync = 1'b1;
      end
   end

   // Read value; unmapped locations and reserved bits read zero
   always_comb begin
      readMux = REG_RESET;
      if (selSync) begin
         readMux[BIT_SYNC_HOLD] = s_r.syncHold;
         readMux[BIT_ASYNC_PSR] = s_r.asyncPsr;
         readMux[BIT_SHARED_PSR] = s_r.sharedPsr;
      end else if (selFlag) begin
         readMux[2:0] = s_r.flags;
      end else if (selPower) begin
         readMux[BIT_POWER] = s_r.powerOn;
      end else if (selMask) begin
         readMux[2:0] = s_r.mask;
      end else if (selCtrlA) begin
         readMux[1:0] = s_r.waveLow;
      end else if (selCtrlB) begin
         readMux[BIT_WAVE_HIGH] = s_r.waveHigh;
         readMux[2:0] = s_r.clkSel;
      end else if (selCount) begin
         readMux = s_r.count;
      end else if (selCmpA) begin
         readMux = s_r.cmpABuf;
      end else if (selCmpB) begin
         readMux = s_r.cmpBBuf;
      end else if (selAsync) begin
         readMux[BIT_ASYNC_SEL] = s_r.asyncSel;
      end
   end

   // Mode decode and the top of the count sequence
   always_comb begin
      waveMode = {s_r.waveHigh, s_r.waveLow};
      isFast = (waveMode == WAVE_FAST_MAX) || (waveMode == WAVE_FAST_CMP);
      isPhase = (waveMode == WAVE_PHASE_MAX) || (waveMode == WAVE_PHASE_CMP);
      topIsCmp = (waveMode == WAVE_CTC) || (waveMode == WAVE_PHASE_CMP) || (waveMode == WAVE_FAST_CMP);
      topValue = topIsCmp ? s_r.cmpAAct : COUNT_MAX;
   end

   // Prescaler tap per clock select code
   always_comb begin
      case (s_r.clkSel)
         3'h1: tapMask = TAP_DIV1;
         3'h2: tapMask = TAP_DIV8;
         3'h3: tapMask = TAP_DIV32;
         3'h4: tapMask = TAP_DIV64;
         3'h5: tapMask = TAP_DIV128;
         3'h6: tapMask = TAP_DIV256;
         default: tapMask = TAP_DIV1024;
      endcase
   end

   // Tick generation; a held async prescaler reset also halts the counter
   always_comb begin
      oscRise = (s_r.osc2 == s_r.osc3) && s_r.osc3 && !s_r.oscLevel;
      srcTick = s_r.asyncSel ? oscRise : 1'b1;
      timerTick = s_r.powerOn && (s_r.clkSel != CLK_SEL_STOP) && srcTick && !s_r.asyncPsr
         && ((s_r.presc & tapMask) == tapMask);
      wrCount = ioReq.wrEn && selCount;
   end

   // Both comparators watch the active values at all times; a counter write masks them for one tick
   for (genvar ch = 0; ch < 2; ch++) begin : g_cmp
      assign cmpHit[ch] = !s_r.blockMatch && (s_r.count == ((ch == 0) ? s_r.cmpAAct : s_r.cmpBAct));
   end

   // Next state
   always_comb begin
      s_nxt = s_r;
      // Three-stage sampling of the crystal pin; a level counts once stages two and three agree
      s_nxt.osc1 = crystalPin1;
      s_nxt.osc2 = s_r.osc1;
      s_nxt.osc3 = s_r.osc2;
      if (s_r.osc2 == s_r.osc3) begin
         s_nxt.oscLevel = s_r.osc3;
      end

      // Prescaler runs free on the source unless its reset is held
      if (s_r.asyncPsr) begin
         s_nxt.presc = 10'h000;
      end else if (srcTick) begin
         s_nxt.presc = s_r.presc + 10'h001;
      end

      // Counter sequence per waveform mode
      if (timerTick) begin
         s_nxt.blockMatch = 1'b0;
         if (isPhase) begin
            if (!s_r.dirDown) begin
               if (s_r.count >= topValue) begin
                  s_nxt.count = s_r.count - COUNT_ONE;
                  s_nxt.dirDown = 1'b1;
               end else begin
                  s_nxt.count = s_r.count + COUNT_ONE;
               end
            end else if (s_r.count == COUNT_BOTTOM) begin
               s_nxt.count = s_r.count + COUNT_ONE;
               s_nxt.dirDown = 1'b0;
            end else begin
               s_nxt.count = s_r.count - COUNT_ONE;
            end
         end else if (isFast && s_r.count == topValue) begin
            s_nxt.count = COUNT_BOTTOM;
            s_nxt.dirDown = 1'b0;
         end else if (waveMode == WAVE_CTC && s_r.count == s_r.cmpAAct) begin
            s_nxt.count = COUNT_BOTTOM;
            s_nxt.dirDown = 1'b0;
         end else begin
            s_nxt.count = s_r.count + COUNT_ONE;
            s_nxt.dirDown = 1'b0;
         end

         // Buffered compare values load at top in phase mode and on wrap in fast mode
         if ((isPhase && !s_r.dirDown && s_r.count >= topValue) || (isFast && s_r.count == topValue)) begin
            s_nxt.cmpAAct = s_r.cmpABuf;
            s_nxt.cmpBAct = s_r.cmpBBuf;
         end
      end

      // Outside PWM modes the comparator follows the written value directly
      if (!isFast && !isPhase) begin
         s_nxt.cmpAAct = s_r.cmpABuf;
         s_nxt.cmpBAct = s_r.cmpBBuf;
      end

      // Flags: acknowledge or write-one clears first, then hardware sets win
      if (ioReq.wrEn && selFlag) begin
         s_nxt.flags = s_r.flags & ~ioReq.wrData[2:0];
      end
      s_nxt.flags = s_nxt.flags & ~intAck;
      if (timerTick) begin
         if (cmpHit[0]) begin
            s_nxt.flags[BIT_FLAG_CMP_A] = 1'b1;
         end
         if (cmpHit[1]) begin
            s_nxt.flags[BIT_FLAG_CMP_B] = 1'b1;
         end
         if (isPhase ? (s_r.dirDown && s_r.count == COUNT_ONE)
                     : isFast ? (s_r.count == topValue)
                              : (s_r.count == COUNT_MAX)) begin
            s_nxt.flags[BIT_FLAG_OVF] = 1'b1;
         end
      end

      // CPU register writes; a counter write overrides the tick above
      if (wrCount) begin
         s_nxt.count = ioReq.wrData;
         s_nxt.blockMatch = 1'b1;
      end
      if (ioReq.wrEn && selCmpA) begin
         s_nxt.cmpABuf = ioReq.wrData;
      end
      if (ioReq.wrEn && selCmpB) begin
         s_nxt.cmpBBuf = ioReq.wrData;
      end
      if (ioReq.wrEn && selMask) begin
         s_nxt.mask = ioReq.wrData[2:0];
      end
      if (ioReq.wrEn && selPower) begin
         s_nxt.powerOn = ioReq.wrData[BIT_POWER];
      end
      if (ioReq.wrEn && selCtrlA) begin
         s_nxt.waveLow = ioReq.wrData[1:0];
      end
      if (ioReq.wrEn && selCtrlB) begin
         s_nxt.waveHigh = ioReq.wrData[BIT_WAVE_HIGH];
         s_nxt.clkSel = ioReq.wrData[2:0];
      end
      if (ioReq.wrEn && selAsync) begin
         s_nxt.asyncSel = ioReq.wrData[BIT_ASYNC_SEL];
      end

      // Sync control: held bits stay; releasing hold drops both resets together
      if (ioReq.wrEn && selSync) begin
         s_nxt.syncHold = ioReq.wrData[BIT_SYNC_HOLD];
         if (s_r.syncHold && !ioReq.wrData[BIT_SYNC_HOLD]) begin
            s_nxt.asyncPsr = 1'b0;
            s_nxt.sharedPsr = 1'b0;
         end else begin
            s_nxt.asyncPsr = ioReq.wrData[BIT_ASYNC_PSR];
            s_nxt.sharedPsr = ioReq.wrData[BIT_SHARED_PSR];
         end
      end else if (!s_r.syncHold) begin
         // A set bit lives exactly one cycle so the reset reaches the prescalers once
         s_nxt.asyncPsr = 1'b0;
         s_nxt.sharedPsr = 1'b0;
      end

      // Read data is registered so the bus sees a stable value one cycle later
      if (ioReq.rdEn) begin
         s_nxt.rdData = readMux;
      end
   end

   // State register; the clock enable freezes everything, synchronisers included
   // Reset does not wait for the clock enable, so a frozen block can still be brought to a known state
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         s_r <= STATE_RESET;
      end else if (clkEn) begin
         s_r <= s_nxt;
      end
   end

   // Outputs
   assign ioRdData = s_r.rdData;
   assign sharedPrescalerReset = s_r.sharedPsr;
   assign intReq = s_r.flags & s_r.mask;
   assign atBottom = (s_r.count == COUNT_BOTTOM);
   assign atMax = (s_r.count == COUNT_MAX);

endmodule : tcu_timer_unit
`default_nettype wire

// File: testbench/tcu_timer_unit_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module tcu_timer_unit_assertions (
   // Clock and control
   input wire logic clk,
   input wire logic rst_b,
   input wire logic clkEn,
   // Watched bus and outputs
   input wire tcu_pkg::tcu_io_req_t ioReq,
   input wire logic [7:0] ioRdData,
   input wire logic [2:0] intReq,
   input wire logic sharedPrescalerReset,
   input wire logic atBottom,
   input wire logic atMax
);
   import tcu_pkg::*;
   logic dWr;
   logic syncWr;
   logic holdSeen_r;
   logic stopSeen_r;
   // Accepted writes; the sync register is the only one here reachable from I/O space
   assign dWr = ioReq.wrEn && clkEn && !ioReq.ioSpace;
   assign syncWr = ioReq.wrEn && clkEn && ioReq.addr == (ioReq.ioSpace ? OFF_SYNC_CTRL - IO_SPACE_OFFSET : OFF_SYNC_CTRL);
   // Shadows of hold and clock select, so the rules can be judged from the pins alone
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         holdSeen_r <= 1'b0;
         stopSeen_r <= 1'b1;
      end else if (clkEn) begin
         if (syncWr) begin
            holdSeen_r <= ioReq.wrData[BIT_SYNC_HOLD];
         end
         if (dWr && ioReq.addr == OFF_CTRL_B) begin
            stopSeen_r <= ioReq.wrData[2:0] == CLK_SEL_STOP;
         end
      end
   end
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_b);
   a_reset_state:
      assert property (disable iff (1'b0) !rst_b && clkEn |=> atBottom && !atMax && intReq == 3'h0
         && ioRdData == 8'h00 && !sharedPrescalerReset) else $error("state after reset wrong");
   a_shared_pulse:
      assert property (syncWr && !ioReq.wrData[7] && ioReq.wrData[0] && !holdSeen_r
         |=> sharedPrescalerReset ##1 (!sharedPrescalerReset || $past(syncWr))) else $error("shared reset pulse wrong");
   a_hold_keeps:
      assert property (holdSeen_r && sharedPrescalerReset && !syncWr |=> sharedPrescalerReset)
         else $error("held shared reset dropped");
   a_release_clears:
      assert property (syncWr && !ioReq.wrData[7] && (holdSeen_r || !ioReq.wrData[0]) |=> !sharedPrescalerReset)
         else $error("release left shared reset set");
   a_io_refused:
      assert property (ioReq.rdEn && clkEn && ioReq.ioSpace && ioReq.addr >= IO_SPACE_LIMIT |=> ioRdData == 8'h00)
         else $error("read beyond I/O window not zero");
   a_mask_gates:
      assert property (dWr && ioReq.addr == OFF_MASK && ioReq.wrData[2:0] == 3'h0 |=> intReq == 3'h0)
         else $error("masked request still raised");
   a_write_wins:
      assert property (dWr && ioReq.addr == OFF_COUNT |=> atBottom == ($past(ioReq.wrData) == COUNT_BOTTOM)
         && atMax == ($past(ioReq.wrData) == COUNT_MAX)) else $error("counter write lost");
   a_stop_freeze:
      assert property (stopSeen_r && !(dWr && ioReq.addr == OFF_COUNT) |=> $stable(atBottom) && $stable(atMax))
         else $error("stopped counter moved");
   a_ends_apart:
      assert property (atBottom |-> !atMax) else $error("bottom and max together");
   a_freeze_hold:
      assert property (rst_b && !clkEn |=> $stable(atBottom) && $stable(atMax) && $stable(ioRdData)
         && $stable(intReq) && $stable(sharedPrescalerReset)) else $error("state moved while frozen");
endmodule : tcu_timer_unit_assertions

bind tcu_timer_unit tcu_timer_unit_assertions u_chk (.clk(clk), .rst_b(rst_b), .clkEn(clkEn), .ioReq(ioReq),
   .ioRdData(ioRdData), .intReq(intReq), .sharedPrescalerReset(sharedPrescalerReset), .atBottom(atBottom),
   .atMax(atMax));
`default_nettype wire

// File: testbench/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
   import tcu_pkg::*;
   logic clk;
   logic rst_b;
   logic clkEn;
   tcu_io_req_t ioReq;
   logic [7:0] ioRdData;
   logic [2:0] intAck;
   logic [2:0] intReq;
   logic crystalPin1;
   logic sharedPrescalerReset;
   logic atBottom;
   logic atMax;
   logic rdTaken;
   logic [7:0] v;
   int n_mismatch;
   int tests_run;
   logic [7:0] expQ[$];
   string nameQ[$];

   tcu_timer_unit uut (.clk(clk), .rst_b(rst_b), .clkEn(clkEn), .ioReq(ioReq), .ioRdData(ioRdData),
      .intAck(intAck), .intReq(intReq), .crystalPin1(crystalPin1),
      .sharedPrescalerReset(sharedPrescalerReset), .atBottom(atBottom), .atMax(atMax));

   // 100 MHz clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task automatic end_of_test();
      $display("Checks %0d, mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : end_of_test

   // One request per cycle, set up at the falling edge so the rising edge sees it settled
   task automatic op(input logic rd, input logic io, input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      ioReq = '{ioSpace: io, addr: a, wrEn: !rd, rdEn: rd, wrData: d};
   endtask : op

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      op(1'b0, 1'b0, a, d);
   endtask : wr

   // Read and note the expected byte for the monitor
   task automatic rd(input logic io, input logic [7:0] a, input logic [7:0] e, input string n);
      op(1'b1, io, a, 8'h00);
      expQ.push_back(e);
      nameQ.push_back(n);
   endtask : rd

   task automatic idle(input int n);
      @(negedge clk);
      ioReq = '0;
      repeat (n) @(negedge clk);
   endtask : idle

   // Read data lands one cycle after the request; the oldest note is compared with it
   always @(posedge clk) rdTaken <= ioReq.rdEn && rst_b && clkEn;
   always @(negedge clk) begin
      if (rdTaken) begin
         if (expQ.size() == 0) begin
            n_mismatch++;
            $display("[FAIL] read without note expected none seen %h", ioRdData);
         end else begin
            check(nameQ.pop_front(), ioRdData, expQ.pop_front());
         end
      end
   end

   // Watchdog: a hang counts as a mismatch
   initial begin
      #200000;
      n_mismatch++;
      end_of_test();
   end

   initial begin
      ioReq = '0;
      rst_b = 1'b0;
      clkEn = 1'b1;
      intAck = 3'h0;
      crystalPin1 = 1'b0;
      n_mismatch = 0;
      tests_run = 0;
      v = 8'($urandom(32'hFB5CEF15));
      repeat (20) @(negedge clk);
      rst_b = 1'b1;
      // Reset values through both address spaces
      rd(1'b0, OFF_SYNC_CTRL, 8'h00, "sync data");
      rd(1'b1, OFF_SYNC_CTRL - IO_SPACE_OFFSET, 8'h00, "sync io");
      rd(1'b0, OFF_COUNT, 8'h00, "count reset");
      idle(1);
      check("bottom", {6'h00, atMax, atBottom}, 8'h01);
      $display("reset test done");
      // I/O space cannot reach extended registers
      wr(OFF_COUNT, 8'hA5);
      op(1'b0, 1'b1, OFF_COUNT - IO_SPACE_OFFSET, 8'h3C);
      rd(1'b1, OFF_COUNT - IO_SPACE_OFFSET, 8'h00, "io beyond");
      rd(1'b0, OFF_COUNT, 8'hA5, "count kept");
      wr(OFF_COUNT, 8'hFF);
      idle(0);
      check("max", {6'h00, atMax, atBottom}, 8'h02);
      $display("space test done");
      // Powered but no clock selected, then clock selected but unpowered
      wr(OFF_POWER, 8'h40);
      idle(10);
      rd(1'b0, OFF_COUNT, 8'hFF, "no select");
      wr(OFF_POWER, 8'h00);
      wr(OFF_CTRL_B, 8'h01);
      wr(OFF_COUNT, 8'h10);
      idle(10);
      rd(1'b0, OFF_COUNT, 8'h10, "power off");
      wr(OFF_POWER, 8'h40);
      wr(OFF_COUNT, 8'hF0);
      rd(1'b0, OFF_COUNT, 8'hF0, "write wins");
      rd(1'b0, OFF_COUNT, 8'hF1, "count up");
      $display("run test done");
      // Overflow in mode 0, mask and acknowledge
      wr(OFF_CMP_A, 8'h80);
      wr(OFF_CMP_B, 8'h90);
      wr(OFF_MASK, 8'h01);
      wr(OFF_FLAG, 8'h07);
      wr(OFF_COUNT, 8'hFD);
      idle(8);
      check("ovf req", {5'h00, intReq}, 8'h01);
      wr(OFF_CTRL_B, 8'h00);
      rd(1'b0, OFF_FLAG, 8'h01, "ovf flag");
      wr(OFF_MASK, 8'h00);
      idle(0);
      check("masked", {5'h00, intReq}, 8'h00);
      intAck = 3'h1;
      @(negedge clk);
      intAck = 3'h0;
      rd(1'b0, OFF_FLAG, 8'h00, "acked");
      $display("overflow test done");
      // Clear on compare A; a free run would wrap and raise overflow
      wr(OFF_CTRL_A, 8'h02);
      wr(OFF_CMP_A, 8'h05);
      wr(OFF_COUNT, 8'h03);
      wr(OFF_CTRL_B, 8'h01);
      idle(300);
      wr(OFF_CTRL_B, 8'h00);
      rd(1'b0, OFF_FLAG, 8'h02, "ctc flags");
      wr(OFF_FLAG, 8'h02);
      rd(1'b0, OFF_FLAG, 8'h00, "w1 clear");
      $display("clear on match test done");
      // A counter write equal to compare B hides the first match
      wr(OFF_CTRL_A, 8'h00);
      wr(OFF_CMP_B, 8'h20);
      wr(OFF_COUNT, 8'h20);
      wr(OFF_CTRL_B, 8'h01);
      idle(4);
      wr(OFF_CTRL_B, 8'h00);
      rd(1'b0, OFF_FLAG, 8'h00, "blocked");
      $display("block test done");
      // Hold keeps both reset bits; release through I/O space clears the shared one
      wr(OFF_SYNC_CTRL, 8'h81);
      idle(2);
      check("held", {7'h00, sharedPrescalerReset}, 8'h01);
      rd(1'b0, OFF_SYNC_CTRL, 8'h81, "held bits");
      op(1'b0, 1'b1, OFF_SYNC_CTRL - IO_SPACE_OFFSET, 8'h00);
      idle(0);
      check("released", {7'h00, sharedPrescalerReset}, 8'h00);
      wr(OFF_SYNC_CTRL, 8'h01);
      idle(0);
      check("pulse", {7'h00, sharedPrescalerReset}, 8'h01);
      rd(1'b0, OFF_SYNC_CTRL, 8'h00, "self clear");
      wr(OFF_CTRL_B, 8'h01);
      wr(OFF_SYNC_CTRL, 8'h82);
      wr(OFF_COUNT, 8'h33);
      idle(10);
      rd(1'b0, OFF_COUNT, 8'h33, "async halt");
      wr(OFF_SYNC_CTRL, 8'h00);
      rd(1'b0, OFF_SYNC_CTRL, 8'h00, "async clr");
      wr(OFF_CTRL_B, 8'h00);
      $display("sync test done");
      // Crystal clock: only pin edges advance the counter
      wr(OFF_ASYNC_STAT, 8'h20);
      wr(OFF_COUNT, 8'h40);
      wr(OFF_CTRL_B, 8'h01);
      idle(10);
      repeat (4) begin
         crystalPin1 = 1'b1;
         repeat (4) @(negedge clk);
         crystalPin1 = 1'b0;
         repeat (4) @(negedge clk);
      end
      rd(1'b0, OFF_COUNT, 8'h44, "crystal");
      wr(OFF_CTRL_B, 8'h00);
      wr(OFF_ASYNC_STAT, 8'h00);
      $display("crystal test done");
      // Clock enable low freezes a running counter
      wr(OFF_COUNT, 8'h50);
      wr(OFF_CTRL_B, 8'h01);
      @(negedge clk);
      ioReq = '0;
      clkEn = 1'b0;
      repeat (5) @(negedge clk);
      clkEn = 1'b1;
      rd(1'b0, OFF_COUNT, 8'h51, "frozen");
      wr(OFF_CTRL_B, 8'h00);
      $display("freeze test done");
      // Every waveform mode code lands in its two registers
      for (int m = 0; m < 8; m++) begin
         wr(OFF_CTRL_A, {6'h00, 2'(m)});
         wr(OFF_CTRL_B, {4'h0, 1'(m >> 2), 3'h0});
         rd(1'b0, OFF_CTRL_A, {6'h00, 2'(m)}, "mode low");
         rd(1'b0, OFF_CTRL_B, {4'h0, 1'(m >> 2), 3'h0}, "mode high");
      end
      wr(OFF_CTRL_A, 8'h00);
      wr(OFF_CTRL_B, 8'h00);
      $display("mode test done");
      // Phase mode with top from compare A; a new compare A waits in the buffer until top
      wr(OFF_CMP_A, 8'h10);
      wr(OFF_COUNT, 8'h0E);
      wr(OFF_CTRL_A, 8'h01);
      wr(OFF_CTRL_B, 8'h09);
      wr(OFF_CMP_A, 8'h40);
      rd(1'b0, OFF_COUNT, 8'h0F, "phase up");
      rd(1'b0, OFF_COUNT, 8'h10, "phase top");
      rd(1'b0, OFF_COUNT, 8'h0F, "phase turn");
      rd(1'b0, OFF_COUNT, 8'h0E, "phase down");
      wr(OFF_CTRL_B, 8'h00);
      wr(OFF_CTRL_A, 8'h00);
      $display("phase test done");
      // Random values through compare B and the stopped counter
      repeat (8) begin
         v = 8'($urandom());
         wr(OFF_CMP_B, v);
         wr(OFF_COUNT, v);
         rd(1'b0, OFF_CMP_B, v, "cmp b");
         rd(1'b0, OFF_COUNT, v, "count rand");
         idle(0);
         check("ends", {6'h00, atMax, atBottom}, {6'h00, v == 8'hFF, v == 8'h00});
      end
      $display("random test done");
      idle(3);
      end_of_test();
   end
endmodule : tb
`default_nettype wire
